// >>> sac_conv_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sac_conv_if;
	import sac_pkg::*;
	logic diff_mode;
	logic start;
	logic [SAC_CHAN_W-1:0] chan;
	logic done;
	logic [SAC_RES_W-1:0] data;
	logic wr_valid;
	logic [SAC_CHAN_W-1:0] wr_chan;
	logic [SAC_RES_W-1:0] wr_data;

	// Sequencer side
	modport seq (
		input diff_mode, done, data,
		output start, chan, wr_valid, wr_chan, wr_data
	);

	// Register side
	modport regs (
		output diff_mode, done, data,
		input start, chan, wr_valid, wr_chan, wr_data
	);
endinterface
`default_nettype wire

// >>> sac_conv_model.sv
`timescale 1ns/100ps
`default_nettype none
module sac_conv_model
	import sac_pkg::*;
(
	input wire logic sys_clk_i, // Clock
	input wire logic start_i, // Start
	input wire logic [SAC_CHAN_W-1:0] chan_i, // Channel
	input wire logic self_i, // Reference in
	input wire logic [1:0] ref_i, // Reference
	input wire logic [SAC_RES_W-1:0] base_i, // Pattern
	output logic done_o, // Done
	output logic [SAC_RES_W-1:0] data_o // Result
);
	int cnt = -1;
	logic [SAC_RES_W-1:0] res;
	initial done_o = 1'b0;
	// Random conversion time, one done pulse, noise otherwise
	always @(posedge sys_clk_i)
	begin
		done_o <= 1'b0;
		data_o <= 12'($urandom);
		if (start_i)
		begin
			cnt <= $urandom_range(300, 4);
			res <= self_i ? {ref_i, 10'h2a5} : base_i + 12'(chan_i) * 12'h025;
		end
		else if (cnt == 0)
		begin
			done_o <= 1'b1;
			data_o <= res;
			cnt <= -1;
		end
		else if (cnt > 0)
			cnt <= cnt - 1;
	end
endmodule
`default_nettype wire

// >>> sac_pkg.sv
`default_nettype none
package sac_pkg;
	// Geometry of the result store
	localparam int unsigned SAC_NUM_CHAN = 32;
	localparam int unsigned SAC_NUM_DIFF = 16;
	localparam int unsigned SAC_CHAN_W = 5;
	localparam int unsigned SAC_RES_W = 12;
	localparam int unsigned SAC_REG_W = 16;
	localparam int unsigned SAC_SIGN_BIT = 11;
	localparam int unsigned SAC_ADDR_W = 7;

	// Register window, byte offsets inside the 128-byte block
	localparam logic [6:0] SAC_RESULT_BASE = 7'h00;
	localparam logic [6:0] SAC_RESULT_LAST = 7'h3e;
	localparam logic [6:0] SAC_CTRL_OFS = 7'h40;
	localparam logic [6:0] SAC_STAT_OFS = 7'h42;

	// Control register fields
	localparam int unsigned SAC_CTRL_IND_BIT = 0;
	localparam int unsigned SAC_CTRL_TWOS_BIT = 1;
	localparam int unsigned SAC_CTRL_SELF_BIT = 2;
	localparam int unsigned SAC_CTRL_REF_LO = 3;
	localparam int unsigned SAC_CTRL_REF_HI = 4;
	localparam logic [15:0] SAC_CTRL_RESET = 16'h0001;

	// Status register fields
	localparam int unsigned SAC_STAT_DIFF_BIT = 0;
	localparam int unsigned SAC_STAT_CHAN_LO = 8;
	localparam int unsigned SAC_STAT_CHAN_HI = 12;

	// Self-check reference selector codes
	localparam logic [1:0] SAC_REF_ZERO = 2'h0;
	localparam logic [1:0] SAC_REF_HIGH = 2'h1;
	localparam logic [1:0] SAC_REF_MID = 2'h2;
	localparam logic [1:0] SAC_REF_LOW = 2'h3;

	// Scan timing
	localparam int unsigned SAC_CLK_MHZ = 100;
	localparam int unsigned SAC_SAMPLE_PERIOD_NS = 24000;
	localparam int unsigned SAC_SAMPLE_CYC = SAC_SAMPLE_PERIOD_NS * SAC_CLK_MHZ / 1000;
	localparam int unsigned SAC_TICK_W = 12;

	typedef enum logic [0:0] {
		SAC_ST_WAIT,
		SAC_ST_CONV
	} sac_seq_state_t;
endpackage
`default_nettype wire

// >>> sac_scan_seq.sv
`timescale 1ns/100ps
`default_nettype none
module sac_scan_seq
	import sac_pkg::*;
(
	input wire logic sys_clk_i, // System clock
	input wire logic rst_i, // Async reset, high
	sac_conv_if.seq cv // Converter and result path
);
	logic [SAC_TICK_W-1:0] tick_cnt_q, tick_cnt_d;
	logic tick;
	sac_seq_state_t state_q, state_d;
	logic start_q, start_d;
	logic [SAC_CHAN_W-1:0] chan_q, chan_d;
	logic wr_valid_q, wr_valid_d;
	logic [SAC_CHAN_W-1:0] wr_chan_q, wr_chan_d;
	logic [SAC_RES_W-1:0] wr_data_q, wr_data_d;

	////////////////////////////////////////////////////////////////
	// Sample pacing and channel walk
	always_comb
	begin
		tick = (tick_cnt_q == SAC_TICK_W'(SAC_SAMPLE_CYC - 1));
		tick_cnt_d = tick ? '0 : tick_cnt_q + 1'b1;
		state_d = state_q;
		start_d = 1'b0;
		chan_d = chan_q;
		wr_valid_d = 1'b0;
		wr_chan_d = wr_chan_q;
		wr_data_d = wr_data_q;
		unique case (state_q)
			SAC_ST_WAIT:
			begin
				if (tick)
				begin
					start_d = 1'b1;
					state_d = SAC_ST_CONV;
				end
			end
			SAC_ST_CONV:
			begin
				if (cv.done)
				begin
					// Whole result moves in one cycle
					wr_valid_d = 1'b1;
					wr_chan_d = chan_q;
					wr_data_d = cv.data;
					if ((cv.diff_mode && chan_q == SAC_CHAN_W'(SAC_NUM_DIFF - 1)) ||
						chan_q == SAC_CHAN_W'(SAC_NUM_CHAN - 1))
						chan_d = '0;
					else
						chan_d = chan_q + 1'b1;
					state_d = SAC_ST_WAIT;
				end
				else if (tick)
					start_d = 1'b1; // Retry a lost conversion
			end
		endcase
	end

	// State registers
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			tick_cnt_q <= '0;
			state_q <= SAC_ST_WAIT;
			start_q <= 1'b0;
			chan_q <= '0;
			wr_valid_q <= 1'b0;
			wr_chan_q <= '0;
			wr_data_q <= '0;
		end
		else
		begin
			tick_cnt_q <= tick_cnt_d;
			state_q <= state_d;
			start_q <= start_d;
			chan_q <= chan_d;
			wr_valid_q <= wr_valid_d;
			wr_chan_q <= wr_chan_d;
			wr_data_q <= wr_data_d;
		end
	end

	// Outputs from flops
	assign cv.start = start_q;
	assign cv.chan = chan_q;
	assign cv.wr_valid = wr_valid_q;
	assign cv.wr_chan = wr_chan_q;
	assign cv.wr_data = wr_data_q;
endmodule
`default_nettype wire

// >>> sac_top.sv
`timescale 1ns/100ps
`default_nettype none
// Function
// - After reset the block scans every configured channel on its own, with no setup.
// - Reset turns the panel indicator on.
// - Reset selects offset-binary coding for all results.
// - The panel indicator goes off only when software clears it.
// - One 12-bit right-aligned result per channel, 32 single-ended or 16 differential.
// - Software picks offset binary or two's complement, applied to every result.
// - In two's complement, bit 11 is copied into bits 12 to 15.
// - Software picks one of four self-check reference levels.
// - Conversions run at no less than 40 thousand samples per second in total.
// - Each result carries 12 bits, code zero at the bottom of the range, 4096 codes.
// - In self-check mode the reference replaces the multiplexer output at the converter.
// - Registers occupy offsets 0x00 to 0x43 of a 128-byte window reached with 16-bit and 8-bit transfers.
module sac_top
	import sac_pkg::*;
(
	input wire logic sys_clk_i, // System clock
	input wire logic rst_i, // Async reset, high
	input wire logic req_i, // Register access strobe
	input wire logic we_i, // Write when high
	input wire logic [SAC_ADDR_W-1:0] addr_i, // Byte offset in window
	input wire logic [1:0] be_i, // Byte lanes, bit1 = high byte
	input wire logic [SAC_REG_W-1:0] wdata_i, // Write data
	output logic ack_o, // Access done pulse
	output logic err_o, // Refused access pulse, unmapped offset or no byte lane
	output logic [SAC_REG_W-1:0] rdata_o, // Read data
	input wire logic diff_mode_i, // Strap, differential inputs
	output logic conv_start_o, // Start conversion pulse
	output logic [SAC_CHAN_W-1:0] mux_sel_o, // Input multiplexer channel
	input wire logic conv_done_i, // Conversion done pulse
	input wire logic [SAC_RES_W-1:0] conv_data_i, // Raw offset-binary result
	output logic self_check_o, // Reference replaces mux
	output logic [1:0] ref_sel_o, // Reference level select
	output logic panel_indicator_o // Front-panel indicator
);
	sac_conv_if cv ();

	logic [SAC_RES_W-1:0] result_mem [SAC_NUM_CHAN];
	logic [SAC_REG_W-1:0] ctrl_q, ctrl_d;
	logic diff_q, diff_d;
	logic strap_taken_q, strap_taken_d;
	logic ack_q, ack_d;
	logic err_q, err_d;
	logic [SAC_REG_W-1:0] rdata_q, rdata_d;
	logic [SAC_REG_W-1:0] rd_word;
	logic hit_result, hit_ctrl, hit_stat;
	logic [SAC_CHAN_W-1:0] rd_chan;
	logic self_check_d;
	logic [1:0] ref_sel_d;

	////////////////////////////////////////////////////////////////
	// Result formatting
	function automatic logic [SAC_REG_W-1:0] sac_code(input logic [SAC_RES_W-1:0] raw, input logic twos);
		logic [SAC_RES_W-1:0] v;
		v = raw;
		if (twos)
		begin
			v[SAC_SIGN_BIT] = ~raw[SAC_SIGN_BIT];
			return {{(SAC_REG_W - SAC_RES_W){v[SAC_SIGN_BIT]}}, v};
		end
		return {{(SAC_REG_W - SAC_RES_W){1'b0}}, v};
	endfunction

	// Byte-lane merge for writes
	function automatic logic [SAC_REG_W-1:0] sac_merge(input logic [SAC_REG_W-1:0] old,
		input logic [SAC_REG_W-1:0] nw, input logic [1:0] be);
		return {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
	endfunction

	////////////////////////////////////////////////////////////////
	// Scan sequencer
	sac_scan_seq u_seq (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.cv(cv.seq)
	);

	assign cv.diff_mode = diff_q;
	assign cv.done = conv_done_i;
	assign cv.data = conv_data_i;

	////////////////////////////////////////////////////////////////
	// Address decode
	always_comb
	begin
		hit_result = (addr_i[SAC_ADDR_W-1:1] <= SAC_RESULT_LAST[SAC_ADDR_W-1:1]);
		hit_ctrl = (addr_i[SAC_ADDR_W-1:1] == SAC_CTRL_OFS[SAC_ADDR_W-1:1]);
		hit_stat = (addr_i[SAC_ADDR_W-1:1] == SAC_STAT_OFS[SAC_ADDR_W-1:1]);
		rd_chan = addr_i[SAC_CHAN_W:1];
		rd_word = '0;
		if (hit_result)
		begin
			if (!diff_q || rd_chan < SAC_CHAN_W'(SAC_NUM_DIFF))
				rd_word = sac_code(result_mem[rd_chan], ctrl_q[SAC_CTRL_TWOS_BIT]);
		end
		else if (hit_ctrl)
			rd_word = ctrl_q;
		else if (hit_stat)
		begin
			rd_word[SAC_STAT_DIFF_BIT] = diff_q;
			rd_word[SAC_STAT_CHAN_HI:SAC_STAT_CHAN_LO] = cv.chan;
		end
	end

	////////////////////////////////////////////////////////////////
	// Register access next state
	always_comb
	begin
		ctrl_d = ctrl_q;
		ack_d = 1'b0;
		err_d = 1'b0;
		rdata_d = rdata_q;
		diff_d = diff_q;
		strap_taken_d = 1'b1;
		if (!strap_taken_q)
			diff_d = diff_mode_i;
		if (req_i)
		begin
			if (!(hit_result || hit_ctrl || hit_stat) || be_i == 2'b00)
				err_d = 1'b1;
			else
			begin
				ack_d = 1'b1;
				if (we_i)
				begin
					if (hit_ctrl)
						ctrl_d = sac_merge(ctrl_q, wdata_i, be_i) & 16'h001f;
				end
				else
					rdata_d = rd_word;
			end
		end
	end

	// Control and bus registers
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ctrl_q <= SAC_CTRL_RESET;
			diff_q <= 1'b0;
			strap_taken_q <= 1'b0;
			ack_q <= 1'b0;
			err_q <= 1'b0;
			rdata_q <= '0;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			diff_q <= diff_d;
			strap_taken_q <= strap_taken_d;
			ack_q <= ack_d;
			err_q <= err_d;
			rdata_q <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// Result store, written whole in one cycle
	always_ff @(posedge sys_clk_i)
	begin
		if (cv.wr_valid)
			result_mem[cv.wr_chan] <= cv.wr_data;
	end

	////////////////////////////////////////////////////////////////
	// Converter side next values
	always_comb
	begin
		self_check_d = ctrl_q[SAC_CTRL_SELF_BIT];
		ref_sel_d = ctrl_q[SAC_CTRL_REF_HI:SAC_CTRL_REF_LO];
	end

	// Converter side outputs
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			self_check_o <= 1'b0;
			ref_sel_o <= SAC_REF_ZERO;
		end
		else
		begin
			self_check_o <= self_check_d;
			ref_sel_o <= ref_sel_d;
		end
	end

	assign conv_start_o = cv.start;
	assign mux_sel_o = cv.chan;
	assign panel_indicator_o = ctrl_q[SAC_CTRL_IND_BIT];
	assign ack_o = ack_q;
	assign err_o = err_q;
	assign rdata_o = rdata_q;
endmodule
`default_nettype wire

// >>> sac_top_chk.sv
`timescale 1ns/100ps
`default_nettype none
module sac_top_chk
	import sac_pkg::*;
(
	input wire logic sys_clk_i, // Clock
	input wire logic rst_i, // Reset
	input wire logic req_i, // Strobe
	input wire logic we_i, // Write
	input wire logic [SAC_ADDR_W-1:0] addr_i, // Offset
	input wire logic [1:0] be_i, // Lanes
	input wire logic [SAC_REG_W-1:0] wdata_i, // Data
	input wire logic ack_o, // Done
	input wire logic err_o, // Refused
	input wire logic conv_start_o, // Start
	input wire logic [1:0] ref_sel_o, // Reference
	input wire logic panel_indicator_o // Indicator
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// Cycles since the last conversion start
	logic [11:0] gap_q;
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			gap_q <= 12'h000;
		else if (conv_start_o)
			gap_q <= 12'h000;
		else if (gap_q != 12'hfff)
			gap_q <= gap_q + 12'h001;
	end
	////////////////////////////////////////////////////////////////
	a_one_answer: assert property (req_i |=> ack_o ^ err_o) else $error("not one answer");
	a_quiet_bus: assert property (!req_i |=> !ack_o && !err_o) else $error("stray answer");
	a_err_refused: assert property (req_i && (addr_i >= 7'h44 || be_i == 2'h0) |=> err_o)
		else $error("refusal missed");
	a_ack_mapped: assert property (req_i && addr_i < 7'h44 && be_i != 2'h0 |=> ack_o)
		else $error("ack missed");
	a_start_spaced: assert property (conv_start_o |=> !conv_start_o [*8]) else $error("start too close");
	a_rate_kept: assert property (gap_q <= 12'h9c4) else $error("scan too slow");
	a_reset_on: assert property ($fell(rst_i) |-> panel_indicator_o) else $error("indicator off");
	a_ind_off: assert property (req_i && we_i && addr_i[6:1] == 6'h20 && be_i[0] && !wdata_i[0]
		|-> ##2 !panel_indicator_o) else $error("indicator stuck");
	a_ref_follow: assert property (req_i && we_i && addr_i[6:1] == 6'h20 && be_i[0]
		|-> ##3 ref_sel_o == $past(wdata_i[4:3], 3)) else $error("reference stale");
endmodule
bind sac_top sac_top_chk i_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_i(req_i), .we_i(we_i),
	.addr_i(addr_i), .be_i(be_i), .wdata_i(wdata_i), .ack_o(ack_o), .err_o(err_o),
	.conv_start_o(conv_start_o), .ref_sel_o(ref_sel_o), .panel_indicator_o(panel_indicator_o));
`default_nettype wire

// >>> scanning_adc_result_control_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module scanning_adc_result_control_tb_top import sac_pkg::*;;
	logic sys_clk_i = 1'b0, rst_i = 1'b1, req_i = 1'b0, we_i = 1'b0, diff_mode_i = 1'b0;
	logic [6:0] addr_i = 7'h00;
	logic [1:0] be_i = 2'h3;
	logic [15:0] wdata_i = 16'h0000;
	logic [11:0] base = 12'h000;
	logic ack_o, err_o, conv_start_o, conv_done_i, self_check_o, panel_indicator_o;
	logic [15:0] rdata_o;
	logic [4:0] mux_sel_o, ch;
	logic [11:0] conv_data_i;
	logic [1:0] ref_sel_o;
	logic [17:0] expq[$];
	logic [17:0] ex;
	int n_mismatch = 0, n_tests = 0;
	always #5 sys_clk_i = ~sys_clk_i;
	sac_top i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_i(req_i), .we_i(we_i), .addr_i(addr_i),
		.be_i(be_i), .wdata_i(wdata_i), .ack_o(ack_o), .err_o(err_o), .rdata_o(rdata_o),
		.diff_mode_i(diff_mode_i), .conv_start_o(conv_start_o), .mux_sel_o(mux_sel_o),
		.conv_done_i(conv_done_i), .conv_data_i(conv_data_i), .self_check_o(self_check_o),
		.ref_sel_o(ref_sel_o), .panel_indicator_o(panel_indicator_o));
	sac_conv_model i_conv (.sys_clk_i(sys_clk_i), .start_i(conv_start_o), .chan_i(mux_sel_o),
		.self_i(self_check_o), .ref_i(ref_sel_o), .base_i(base), .done_o(conv_done_i), .data_o(conv_data_i));
	////////////////////////////////////////////////////////////////
	task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tally_and_finish();
		n_mismatch += expq.size();
		$display("compares %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// One access; expectation is {check data, error, data}
	task automatic acc(input logic w, input logic [6:0] a, input logic [1:0] b, input logic [15:0] d,
		input logic [17:0] e);
		@(posedge sys_clk_i);
		req_i <= 1'b1;
		we_i <= w;
		addr_i <= a;
		be_i <= b;
		wdata_i <= d;
		expq.push_back(e);
		@(posedge sys_clk_i);
		req_i <= 1'b0;
	endtask
	task automatic wait_ch(input logic [4:0] c);
		int i;
		for (i = 0; i < 25000 && mux_sel_o !== c; i++)
			@(negedge sys_clk_i);
		if (i == 25000)
		begin
			n_mismatch++;
			tally_and_finish();
		end
		repeat (3) @(posedge sys_clk_i);
	endtask
	function automatic logic [17:0] rd(input logic [15:0] v);
		return {2'b10, v};
	endfunction
	function automatic logic [11:0] pat(input int c);
		return base + 12'(c) * 12'h025;
	endfunction
	// Two's complement view of a raw offset-binary result
	function automatic logic [15:0] tc(input logic [11:0] v);
		return {{5{~v[11]}}, v[10:0]};
	endfunction
	// Answer watcher
	always @(negedge sys_clk_i)
		if (ack_o === 1'b1 || err_o === 1'b1)
		begin
			ex = expq.size() > 0 ? expq.pop_front() : 18'h3_ffff;
			cmp("err_o", {15'h0000, ex[16]}, {15'h0000, err_o});
			if (ex[17])
				cmp("rdata_o", ex[15:0], rdata_o);
		end
	// Main sequence
	initial
	begin
		void'($urandom(11));
		base <= 12'($urandom);
		repeat (2) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		acc(1'b0, SAC_CTRL_OFS, 2'h3, 16'h0000, rd(16'h0001));
		cmp("indicator", 16'h0001, {15'h0000, panel_indicator_o});
		wait_ch(5'h08);
		for (int c = 0; c < 8; c++)
			acc(1'b0, 7'(c * 2), 2'h3, 16'h0000, rd({4'h0, pat(c)}));
		acc(1'b1, SAC_CTRL_OFS, 2'h3, 16'h0002, 18'h0_0000);
		@(posedge sys_clk_i);
		cmp("indicator", 16'h0000, {15'h0000, panel_indicator_o});
		for (int c = 0; c < 8; c++)
			acc(1'b0, 7'(c * 2), 2'h3, 16'h0000, rd(tc(pat(c))));
		for (int r = 0; r < 4; r++)
		begin
			acc(1'b1, SAC_CTRL_OFS, 2'h3, 16'(4 + r * 8), 18'h0_0000);
			@(negedge sys_clk_i);
			ch = mux_sel_o + 5'h01;
			wait_ch(ch + 5'h01);
			cmp("ref_sel_o", 16'(r), {14'h0000, ref_sel_o});
			cmp("self_check_o", 16'h0001, {15'h0000, self_check_o});
			acc(1'b0, {1'b0, ch, 1'b0}, 2'h3, 16'h0000, rd({4'h0, 2'(r), 10'h2a5}));
		end
		acc(1'b0, 7'h50, 2'h3, 16'h0000, 18'h1_0000);
		acc(1'b1, SAC_CTRL_OFS, 2'h0, 16'h0000, 18'h1_0000);
		acc(1'b1, SAC_CTRL_OFS, 2'h2, 16'hffff, 18'h0_0000);
		acc(1'b0, SAC_CTRL_OFS, 2'h3, 16'h0000, rd(16'h001c));
		acc(1'b1, SAC_CTRL_OFS, 2'h1, 16'hff01, 18'h0_0000);
		acc(1'b0, SAC_CTRL_OFS, 2'h3, 16'h0000, rd(16'h0001));
		@(posedge sys_clk_i);
		diff_mode_i <= 1'b1;
		rst_i <= 1'b1;
		@(posedge sys_clk_i);
		rst_i <= 1'b0;
		acc(1'b0, SAC_STAT_OFS, 2'h3, 16'h0000, rd(16'h0001));
		acc(1'b0, 7'h28, 2'h3, 16'h0000, rd(16'h0000));
		repeat (2) @(posedge sys_clk_i);
		tally_and_finish();
	end
endmodule
`default_nettype wire
